/* rtl/umc_core.sv */
// UART multiprocessor core: transmitter, receiver, soft reset and flags.
// Assumes control bits come from software registers on clock_i; the
// serial input pin is asynchronous. Bit clock is clock_i / baud_div_i.
// Function
// - Asynchronous mode only when clocked-mode select clear
// - One baud setting times transmit and receive
// - Power-up clear sets soft reset bit
// - Soft reset clears flags, sets transmit-ready flags
// - Soft reset leaves receive/transmit enables alone
// - Clearing soft reset releases normal operation
// - Start, 7/8 data, address, parity, stops
// - Data bits travel least significant first
// - Format select zero means idle-line format
// - Idle line: ten marks after first stop
// - First char after idle tagged as address
// - Idle-line filter drops non-address characters
// - Load copies address mark to wake latch
// - Wake latch sends exactly eleven idle marks
// - Dummy never sent; next follows idle
// - Address-bit format tags received address chars
// - Address-bit filter drops address-bit-zero chars
// - Address mark becomes transmitted address bit
// - Only hardware clears the address mark
// - Three-sample majority vote, failed start aborts
// - Any error flag also sets summary error
`timescale 1ns/1ps
module umc_core (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Serial pins
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	// Software writes
	input wire logic soft_reset_bit_wr_i,
	input wire logic soft_reset_bit_data_i,
	input wire logic en_wr_i,
	input wire logic rx_en_data_i,
	input wire logic tx_en_data_i,
	input wire logic ie_wr_i,
	input wire logic rx_ie_data_i,
	input wire logic tx_ie_data_i,
	input wire logic tx_mark_set_i,
	input wire logic rx_read_i,
	input wire logic err_clr_i,
	// Configuration levels
	input wire logic sync_mode_i,
	input wire logic char7_i,
	input wire logic parity_en_i,
	input wire logic parity_even_i,
	input wire logic two_stop_i,
	input wire logic multiproc_format_select_i,
	input wire logic rx_wake_filter_enable_i,
	input wire logic [umc_pkg::DIV_WIDTH-1:0] baud_div_i,
	// Transmit buffer write
	input wire logic tx_write_i,
	input wire logic [umc_pkg::CHAR_WIDTH-1:0] tx_data_i,
	output logic tx_ready_flag_o,
	// Status
	output logic [umc_pkg::CHAR_WIDTH-1:0] rx_buffer_o,
	output logic rx_irq_flag_o,
	output logic rx_address_tag_o,
	output logic tx_address_mark_o,
	output logic tx_shift_empty_o,
	output logic rx_any_error_o,
	output logic line_break_flag_o,
	output logic parity_error_flag_o,
	output logic overrun_flag_o,
	output logic framing_flag_o,
	output logic soft_reset_bit_o,
	output logic rx_enable_o,
	output logic tx_enable_o,
	output logic rx_irq_enable_o,
	output logic tx_irq_enable_o
);
	import umc_pkg::*;

	typedef struct packed {
		logic soft_reset;
		logic rx_en;
		logic tx_en;
		logic rx_ie;
		logic tx_ie;
		logic rx_flag;
		logic rx_tag;
		logic tx_mark;
		logic rx_err;
		logic line_break_flag;
		logic pe;
		logic oe;
		logic fe;
		logic tx_empty;
		logic [CHAR_WIDTH-1:0] rx_buf;
		umc_rx_state_type rx_st;
		logic [DIV_WIDTH-1:0] rx_cnt;
		logic [3:0] rx_pos;
		logic rx_s0;
		logic rx_s1;
		logic [PAYLOAD_BITS-1:0] rx_sh;
		logic [IDLE_CNT_WIDTH-1:0] idle_cnt;
		logic idle_seen;
		umc_tx_state_type tx_st;
		logic [DIV_WIDTH-1:0] tx_cnt;
		logic [3:0] tx_pos;
		logic [3:0] tx_len;
		logic [FRAME_BITS-1:0] tx_vec;
		logic wake_temp_latch;
		logic txd;
	} umc_core_type;

	umc_core_type s;
	umc_core_type next_s;
	logic rxd;
	logic fifo_valid;
	logic [CHAR_WIDTH-1:0] fifo_data;
	logic pop;
	logic run;
	logic vote;
	logic rx_fin;
	logic addr_char;
	logic keep;
	logic pe_now;
	logic [3:0] nlen;
	logic [DIV_WIDTH-1:0] half;
	logic [IDLE_CNT_WIDTH-1:0] idle_thr;
	logic [FRAME_BITS+3:0] frm;

	// ==========================================
	// Frame builder: returns {length, bits}, bit 0 sent first
	function automatic logic [FRAME_BITS+3:0] build_frame(input logic [7:0] d,
		input logic c7, input logic pen, input logic peven, input logic mm,
		input logic mark, input logic two);
		logic [FRAME_BITS-1:0] v;
		logic [3:0] p;
		logic par;
		v = '1;
		v[0] = 1'b0;
		p = 4'h1;
		for (int i = 0; i < 8; i++) begin
			if (i < 7 || !c7) begin
				v[p] = d[i];
				p = p + 4'h1;
			end
		end
		par = ^(c7 ? {1'b0, d[6:0]} : d) ^ (mm & mark);
		if (mm) begin
			v[p] = mark;
			p = p + 4'h1;
		end
		if (pen) begin
			v[p] = peven ? par : ~par;
			p = p + 4'h1;
		end
		return {p + 4'h1 + {3'h0, two}, v};
	endfunction : build_frame

	// ==========================================
	// Pin synchroniser and transmit buffer
	umc_pin_sync u_sync (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.pin_i(serial_in_pin_i),
		.level_o(rxd)
	);

	// Buffer flushed while in soft reset so ready reads as set
	umc_fifo #(
		.WIDTH(CHAR_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.flush_i(s.soft_reset),
		.in_valid_i(tx_write_i),
		.in_data_i(tx_data_i),
		.in_ready_o(tx_ready_flag_o),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_data),
		.out_ready_i(pop)
	);

	// ==========================================
	// Next state
	always_comb begin
		next_s = s;
		pop = 1'b0;
		rx_fin = 1'b0;
		run = !s.soft_reset && !sync_mode_i;
		half = baud_div_i >> 1;
		nlen = umc_payload_len(char7_i, parity_en_i, multiproc_format_select_i);
		vote = (s.rx_s0 & s.rx_s1) | (s.rx_s0 & rxd) | (s.rx_s1 & rxd);
		idle_thr = IDLE_CNT_WIDTH'(baud_div_i) * IDLE_CNT_WIDTH'(IDLE_MARKS)
			+ IDLE_CNT_WIDTH'(half);
		frm = build_frame(fifo_data, char7_i, parity_en_i, parity_even_i,
			multiproc_format_select_i, s.tx_mark, two_stop_i);
		addr_char = multiproc_format_select_i ? s.rx_sh[char7_i ? 7 : 8] : s.idle_seen;
		keep = !rx_wake_filter_enable_i || addr_char;
		pe_now = parity_en_i && ((^s.rx_sh) == parity_even_i);

		// Software writes; clears first so hardware sets win below
		if (soft_reset_bit_wr_i) begin
			next_s.soft_reset = soft_reset_bit_data_i;
		end
		if (en_wr_i) begin
			next_s.rx_en = rx_en_data_i;
			next_s.tx_en = tx_en_data_i;
		end
		if (ie_wr_i) begin
			next_s.rx_ie = rx_ie_data_i;
			next_s.tx_ie = tx_ie_data_i;
		end
		if (tx_mark_set_i) begin
			next_s.tx_mark = 1'b1;
		end
		if (rx_read_i || err_clr_i) begin
			{next_s.fe, next_s.pe, next_s.oe, next_s.line_break_flag} = 4'h0;
		end
		if (rx_read_i) begin
			next_s.rx_flag = 1'b0;
		end

		// Transmitter; both shifters count the same divider
		case (s.tx_st)
			UMC_TX_IDLE: begin
				if (run && s.tx_en && fifo_valid) begin
					pop = 1'b1;
					next_s.tx_st = UMC_TX_BUSY;
					next_s.tx_cnt = '0;
					next_s.tx_pos = 4'h0;
					next_s.wake_temp_latch = s.tx_mark;
					next_s.tx_mark = tx_mark_set_i;
					if (!multiproc_format_select_i && s.tx_mark) begin
						next_s.tx_vec = '1;
						next_s.tx_len = WAKE_MARKS;
					end else begin
						{next_s.tx_len, next_s.tx_vec} = frm;
					end
					next_s.txd = next_s.tx_vec[0];
				end
			end
			UMC_TX_BUSY: begin
				if (s.tx_cnt == baud_div_i - 16'h1) begin
					next_s.tx_cnt = '0;
					next_s.tx_pos = s.tx_pos + 4'h1;
					if (next_s.tx_pos == s.tx_len) begin
						next_s.tx_st = UMC_TX_IDLE;
						next_s.txd = LINE_MARK;
					end else begin
						next_s.txd = s.tx_vec[next_s.tx_pos];
					end
				end else begin
					next_s.tx_cnt = s.tx_cnt + 16'h1;
				end
			end
			default: begin
				next_s.tx_st = UMC_TX_IDLE;
			end
		endcase
		next_s.tx_empty = (next_s.tx_st == UMC_TX_IDLE) && !fifo_valid;

		// Receiver: idle-line count, then sample and vote each bit
		case (s.rx_st)
			UMC_RX_IDLE: begin
				if (!rxd) begin
					next_s.idle_cnt = '0;
				end else if (s.idle_cnt == idle_thr) begin
					next_s.idle_seen = 1'b1;
				end else begin
					next_s.idle_cnt = s.idle_cnt + 1'b1;
				end
				if (run && s.rx_en && !rxd) begin
					next_s.rx_st = UMC_RX_BUSY;
					next_s.rx_cnt = '0;
					next_s.rx_pos = 4'h0;
					next_s.rx_sh = '0;
					next_s.idle_cnt = '0;
				end
			end
			UMC_RX_BUSY: begin
				next_s.rx_cnt = s.rx_cnt + 16'h1;
				if (s.rx_cnt == half - 16'h1) begin
					next_s.rx_s0 = rxd;
				end
				if (s.rx_cnt == half) begin
					next_s.rx_s1 = rxd;
				end
				if (s.rx_cnt == half + 16'h1) begin
					if (s.rx_pos == 4'h0) begin
						if (vote) begin
							next_s.rx_st = UMC_RX_IDLE;
						end
					end else if (s.rx_pos <= nlen) begin
						next_s.rx_sh[s.rx_pos - 4'h1] = vote;
					end else begin
						rx_fin = 1'b1;
						next_s.rx_st = UMC_RX_IDLE;
					end
				end
				if (s.rx_cnt == baud_div_i - 16'h1) begin
					next_s.rx_cnt = '0;
					next_s.rx_pos = s.rx_pos + 4'h1;
				end
			end
			default: begin
				next_s.rx_st = UMC_RX_IDLE;
			end
		endcase

		// Character done at the first stop; filter decides storage
		if (rx_fin) begin
			next_s.idle_seen = 1'b0;
			if (keep) begin
				next_s.rx_buf = char7_i ? {1'b0, s.rx_sh[6:0]} : s.rx_sh[7:0];
				next_s.rx_tag = addr_char;
				next_s.rx_flag = 1'b1;
				if (!vote) begin
					next_s.fe = 1'b1;
				end
				if (!vote && s.rx_sh == '0) begin
					next_s.line_break_flag = 1'b1;
				end
				if (pe_now) begin
					next_s.pe = 1'b1;
				end
				if (s.rx_flag && !rx_read_i) begin
					next_s.oe = 1'b1;
				end
			end
		end
		next_s.rx_err = next_s.fe | next_s.pe | next_s.oe | next_s.line_break_flag;

		// Soft reset holds flags and interrupt enables clear; receive/transmit enables untouched
		if (s.soft_reset) begin
			{next_s.rx_ie, next_s.tx_ie, next_s.rx_flag, next_s.rx_tag} = 4'h0;
			{next_s.tx_mark, next_s.rx_err, next_s.line_break_flag, next_s.pe} = 4'h0;
			{next_s.oe, next_s.fe} = 2'h0;
			next_s.tx_empty = 1'b1;
			next_s.rx_st = UMC_RX_IDLE;
			next_s.tx_st = UMC_TX_IDLE;
			next_s.txd = LINE_MARK;
		end
		if (sync_mode_i) begin
			next_s.rx_st = UMC_RX_IDLE;
			next_s.tx_st = UMC_TX_IDLE;
			next_s.txd = LINE_MARK;
		end
	end

	// Registers; power-up leaves the core held in soft reset
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			s <= '0;
			s.soft_reset <= SOFT_RESET_RST;
			s.tx_empty <= 1'b1;
			s.txd <= LINE_MARK;
			s.rx_s0 <= LINE_MARK;
			s.rx_s1 <= LINE_MARK;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================
	// Outputs, all straight from flops
	assign serial_out_pin_o = s.txd;
	assign rx_buffer_o = s.rx_buf;
	assign rx_irq_flag_o = s.rx_flag;
	assign rx_address_tag_o = s.rx_tag;
	assign tx_address_mark_o = s.tx_mark;
	assign tx_shift_empty_o = s.tx_empty;
	assign rx_any_error_o = s.rx_err;
	assign line_break_flag_o = s.line_break_flag;
	assign parity_error_flag_o = s.pe;
	assign overrun_flag_o = s.oe;
	assign framing_flag_o = s.fe;
	assign soft_reset_bit_o = s.soft_reset;
	assign rx_enable_o = s.rx_en;
	assign tx_enable_o = s.tx_en;
	assign rx_irq_enable_o = s.rx_ie;
	assign tx_irq_enable_o = s.tx_ie;

	// ==========================================
	// Checks
	reset_clears_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		s.soft_reset |=> (!s.rx_flag && !s.rx_tag && !s.tx_mark && !s.rx_err
			&& !s.rx_ie && !s.tx_ie && s.tx_empty && s.txd))
		else $error("soft reset left a flag set");
	reset_holds_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(s.soft_reset && !soft_reset_bit_wr_i) |=> s.soft_reset)
		else $error("soft reset dropped without a write");
	reset_release_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(soft_reset_bit_wr_i && !soft_reset_bit_data_i) |=> !s.soft_reset)
		else $error("soft reset not released");
	enable_keep_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(s.soft_reset && !en_wr_i) |=> (s.rx_en == $past(s.rx_en)
			&& s.tx_en == $past(s.tx_en)))
		else $error("enable changed by soft reset");
	error_sum_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(s.fe || s.pe || s.oe || s.line_break_flag) |-> s.rx_err)
		else $error("summary error missing");
	mark_move_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(pop && !tx_mark_set_i) |=> (!s.tx_mark && s.wake_temp_latch == $past(s.tx_mark)))
		else $error("address mark not moved to wake latch");
	wake_idle_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(pop && !multiproc_format_select_i && s.tx_mark) |=> s.txd [*8])
		else $error("wake frame left mark level");
	start_bit_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(pop && !(!multiproc_format_select_i && s.tx_mark)) |=> !s.txd)
		else $error("start bit not driven");
	filter_drop_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(rx_fin && rx_wake_filter_enable_i && !addr_char)
			|=> (s.rx_buf == $past(s.rx_buf) && !$rose(s.rx_flag)))
		else $error("filtered character stored");
	tag_store_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(rx_fin && addr_char && !s.soft_reset) |=> (s.rx_tag && s.rx_flag))
		else $error("address character not tagged");
	vote_abort_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(s.rx_st == UMC_RX_BUSY && s.rx_pos == 4'h0 && s.rx_cnt == half + 16'h1
			&& vote) |=> s.rx_st == UMC_RX_IDLE)
		else $error("false start not abandoned");
	sync_idle_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		sync_mode_i |=> (s.txd && s.rx_st == UMC_RX_IDLE))
		else $error("serial logic active in clocked mode");

endmodule : umc_core

/* rtl/umc_fifo.sv */
// Transmit character FIFO with valid/ready on both sides and a flush.
// Assumes the drain side may hold ready low for any length of time.
`timescale 1ns/1ps
module umc_fifo #(
	parameter int WIDTH = umc_pkg::CHAR_WIDTH,
	parameter int DEPTH = umc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic flush_i,
	// Fill side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	import umc_pkg::*;

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic rdy;
		logic val;
	} umc_fifo_type;

	umc_fifo_type s;
	umc_fifo_type next_s;
	logic push;
	logic pop;

	// ==========================================
	// Pointer and count update; flags kept in flops for clean outputs
	always_comb begin
		next_s = s;
		push = in_valid_i && s.rdy;
		pop = out_ready_i && s.val;
		if (push) begin
			next_s.mem[s.wp] = in_data_i;
			next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
		end
		if (pop) begin
			next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
		end
		next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (flush_i) begin
			next_s.wp = '0;
			next_s.rp = '0;
			next_s.cnt = '0;
		end
		next_s.rdy = (next_s.cnt != (AW+1)'(DEPTH));
		next_s.val = (next_s.cnt != '0);
	end

	// Registers
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			s <= '0;
			s.rdy <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign in_ready_o = s.rdy;
	assign out_valid_o = s.val;
	assign out_data_o = s.mem[s.rp];

	// Count never passes the depth
	fifo_bound_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		s.cnt <= (AW+1)'(DEPTH) && (s.rdy == (s.cnt != (AW+1)'(DEPTH))))
		else $error("fifo count out of range");

endmodule : umc_fifo

/* rtl/umc_pin_sync.sv */
// Three-stage synchroniser with agreement filter for the serial input pin.
// Assumes the pin is asynchronous to clock_i and idles at mark.
`timescale 1ns/1ps
module umc_pin_sync (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Pin and filtered level
	input wire logic pin_i,
	output logic level_o
);
	import umc_pkg::*;

	typedef struct packed {
		logic f1;
		logic f2;
		logic f3;
		logic lvl;
	} umc_sync_type;

	umc_sync_type s;
	umc_sync_type next_s;

	// ==========================================
	// Next state: level moves only when stages two and three agree
	always_comb begin
		next_s = s;
		next_s.f1 = pin_i;
		next_s.f2 = s.f1;
		next_s.f3 = s.f2;
		if (s.f2 == s.f3) begin
			next_s.lvl = s.f3;
		end
	end

	// Registers, line assumed idle at reset
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			s <= {4{LINE_MARK}};
		end else begin
			s <= next_s;
		end
	end

	assign level_o = s.lvl;

endmodule : umc_pin_sync

/* rtl/umc_pkg.sv */
// Shared constants, state types and decoding for the UART multiprocessor core.
// Assumes a single 100 MHz clock domain; no surroundings beyond the core itself.
package umc_pkg;

	// ==========================================
	// Reset values and line levels
	localparam logic SOFT_RESET_RST = 1'b1;
	localparam logic LINE_MARK = 1'b1;

	// ==========================================
	// Character and idle timing, in bit periods
	localparam logic [3:0] IDLE_MARKS = 4'ha;
	localparam logic [3:0] WAKE_MARKS = 4'hb;
	localparam int FRAME_BITS = 13;
	localparam int PAYLOAD_BITS = 10;
	localparam int CHAR_WIDTH = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int DIV_WIDTH = 16;
	localparam int IDLE_CNT_WIDTH = 20;

	// ==========================================
	// State types
	typedef enum logic {UMC_RX_IDLE, UMC_RX_BUSY} umc_rx_state_type;
	typedef enum logic {UMC_TX_IDLE, UMC_TX_BUSY} umc_tx_state_type;

	// Bits between start and stop: data, address, parity
	function automatic logic [3:0] umc_payload_len(input logic c7, input logic pen,
		input logic mm);
		return (c7 ? 4'h7 : 4'h8) + {3'h0, pen} + {3'h0, mm};
	endfunction : umc_payload_len

endpackage : umc_pkg

/* testbench/uart_multiprocessor_core_test.sv */
// Self-checking bench for the UART multiprocessor core.
// Assumes the remote model owns the receive pin and watches the transmit pin.
`timescale 1ns/1ps
module uart_multiprocessor_core_test;
	import umc_pkg::*;
	localparam int N = 8;
	logic clock_i = 1'b0;
	logic rstn_i, serial_in_pin_i, serial_out_pin_o, soft_reset_bit_wr_i, soft_reset_bit_data_i, en_wr_i;
	logic rx_en_data_i, tx_en_data_i, ie_wr_i, rx_ie_data_i, tx_ie_data_i, tx_mark_set_i;
	logic rx_read_i, err_clr_i, sync_mode_i, char7_i, parity_en_i, parity_even_i;
	logic two_stop_i, multiproc_format_select_i, rx_wake_filter_enable_i, tx_write_i;
	logic tx_ready_flag_o, rx_irq_flag_o, rx_address_tag_o, tx_address_mark_o;
	logic tx_shift_empty_o, rx_any_error_o, line_break_flag_o, parity_error_flag_o;
	logic overrun_flag_o, framing_flag_o, soft_reset_bit_o, rx_enable_o, tx_enable_o;
	logic rx_irq_enable_o, tx_irq_enable_o;
	logic [DIV_WIDTH-1:0] baud_div_i;
	logic [CHAR_WIDTH-1:0] tx_data_i, rx_buffer_o;
	int n_fail = 0;
	int n_tests = 0;

	// ==========================================
	// Clock, design and remote device
	always #5 clock_i = ~clock_i;

	umc_core i_umc_core (.clock_i, .rstn_i, .serial_in_pin_i, .serial_out_pin_o, .soft_reset_bit_wr_i,
		.soft_reset_bit_data_i, .en_wr_i, .rx_en_data_i, .tx_en_data_i, .ie_wr_i, .rx_ie_data_i,
		.tx_ie_data_i, .tx_mark_set_i, .rx_read_i, .err_clr_i, .sync_mode_i, .char7_i,
		.parity_en_i, .parity_even_i, .two_stop_i, .multiproc_format_select_i,
		.rx_wake_filter_enable_i, .baud_div_i, .tx_write_i, .tx_data_i, .tx_ready_flag_o,
		.rx_buffer_o, .rx_irq_flag_o, .rx_address_tag_o, .tx_address_mark_o,
		.tx_shift_empty_o, .rx_any_error_o, .line_break_flag_o, .parity_error_flag_o,
		.overrun_flag_o, .framing_flag_o, .soft_reset_bit_o, .rx_enable_o, .tx_enable_o,
		.rx_irq_enable_o, .tx_irq_enable_o);

	umc_remote_model i_umc_remote_model (.clock_i, .from_dut_i(serial_out_pin_o),
		.to_dut_o(serial_in_pin_i));

	// ==========================================
	// Helpers
	task automatic step();
		@(posedge clock_i);
		#1;
	endtask : step

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Expected frame from the current format levels, start bit at index 0
	function automatic logic [15:0] frame(input logic [7:0] d, input logic a,
		input logic bad_par, input logic bad_stop, output int n);
		logic [15:0] f;
		logic p;
		f = 16'h0;
		n = 1;
		p = ^(char7_i ? {1'b0, d[6:0]} : d) ^ (multiproc_format_select_i & a);
		for (int i = 0; i < (char7_i ? 7 : 8); i++) begin
			f[n] = d[i];
			n++;
		end
		if (multiproc_format_select_i) begin
			f[n] = a;
			n++;
		end
		if (parity_en_i) begin
			f[n] = (parity_even_i ? p : ~p) ^ bad_par;
			n++;
		end
		f[n] = ~bad_stop;
		n++;
		if (two_stop_i) begin
			f[n] = 1'b1;
			n++;
		end
		return f;
	endfunction : frame

	// Reprogram format inside a soft reset window: sync,c7,pen,peven,two,mm
	task automatic cfg(input logic [5:0] c);
		soft_reset_bit_data_i = 1'b1;
		soft_reset_bit_wr_i = 1'b1;
		step();
		{sync_mode_i, char7_i, parity_en_i, parity_even_i, two_stop_i,
			multiproc_format_select_i} = c;
		soft_reset_bit_data_i = 1'b0;
		step();
		soft_reset_bit_wr_i = 1'b0;
		step();
	endtask : cfg

	task automatic put(input logic [7:0] d);
		check(tx_ready_flag_o, 1'b1);
		tx_data_i = d;
		tx_write_i = 1'b1;
		step();
		tx_write_i = 1'b0;
	endtask : put

	task automatic mark();
		tx_mark_set_i = 1'b1;
		step();
		tx_mark_set_i = 1'b0;
		step();
	endtask : mark

	task automatic rd();
		rx_read_i = 1'b1;
		step();
		rx_read_i = 1'b0;
		step();
	endtask : rd

	// Capture one transmitted frame; a silent line ends the run
	task automatic expect_tx(input logic [7:0] d, input logic a, output int idle);
		logic [15:0] got;
		int n;
		logic ok;
		i_umc_remote_model.recv(n_bits(d, a), N, got, idle, ok);
		check(ok, 1'b1);
		if (ok !== 1'b1) begin
			end_sim();
		end
		check(got, frame(d, a, 1'b0, 1'b0, n));
	endtask : expect_tx

	function automatic int n_bits(input logic [7:0] d, input logic a);
		int n;
		void'(frame(d, a, 1'b0, 1'b0, n));
		return n;
	endfunction : n_bits

	task automatic rx(input logic [7:0] d, input logic a, input logic bp, input logic bs);
		int n;
		logic [15:0] f;
		f = frame(d, a, bp, bs, n);
		i_umc_remote_model.send(f, n, N);
	endtask : rx

	// ==========================================
	// Main sequence
	initial begin
		int idle;
		int lows;
		{rstn_i, soft_reset_bit_wr_i, soft_reset_bit_data_i, en_wr_i, rx_en_data_i, tx_en_data_i} = 6'h0;
		{ie_wr_i, rx_ie_data_i, tx_ie_data_i, tx_mark_set_i, rx_read_i, err_clr_i} = 6'h0;
		{sync_mode_i, char7_i, parity_en_i, parity_even_i, two_stop_i} = 5'h0;
		{multiproc_format_select_i, rx_wake_filter_enable_i, tx_write_i} = 3'h0;
		tx_data_i = 8'h00;
		baud_div_i = 16'(N);
		repeat (12) @(posedge clock_i);
		#1;
		rstn_i = 1'b1;
		step();
		check({soft_reset_bit_o, tx_ready_flag_o, tx_shift_empty_o, serial_out_pin_o}, 4'hf);
		check({rx_irq_flag_o, rx_address_tag_o, tx_address_mark_o, rx_any_error_o,
			line_break_flag_o, parity_error_flag_o, overrun_flag_o, framing_flag_o}, 8'h00);
		// Enables, interrupt enables and mark written while held in soft reset
		{en_wr_i, rx_en_data_i, tx_en_data_i, ie_wr_i, rx_ie_data_i, tx_ie_data_i} = 6'h3f;
		tx_mark_set_i = 1'b1;
		step();
		{en_wr_i, ie_wr_i, tx_mark_set_i} = 3'h0;
		step();
		check({rx_enable_o, tx_enable_o}, 2'h3);
		check({rx_irq_enable_o, tx_irq_enable_o, tx_address_mark_o}, 3'h0);
		cfg(6'h00);
		check(soft_reset_bit_o, 1'b0);
		ie_wr_i = 1'b1;
		step();
		ie_wr_i = 1'b0;
		step();
		check({rx_irq_enable_o, tx_irq_enable_o}, 2'h3);
		cfg(6'h00);
		check({rx_irq_enable_o, tx_irq_enable_o, rx_enable_o, tx_enable_o}, 4'h3);

		// ==========================================
		// Transmit: plain, 7-bit odd parity, address bit with two stops
		put(8'hb4);
		expect_tx(8'hb4, 1'b0, idle);
		cfg(6'h18);
		put(8'hd5);
		expect_tx(8'hd5, 1'b0, idle);
		cfg(6'h0f);
		mark();
		check(tx_address_mark_o, 1'b1);
		put(8'h3c);
		expect_tx(8'h3c, 1'b1, idle);
		check(tx_address_mark_o, 1'b0);
		put(8'h3c);
		expect_tx(8'h3c, 1'b0, idle);
		// Wake idle with one and with two stop bits: dummy never shows
		for (int k = 0; k < 2; k++) begin
			cfg(k == 0 ? 6'h00 : 6'h02);
			mark();
			put(8'hff);
			// Let an edge pass so the write strobe is not raised again in the same step
			step();
			put(8'h96);
			expect_tx(8'h96, 1'b0, idle);
			check(idle >= 11 * N && idle <= 11 * N + 6, 1'b1);
			check(tx_address_mark_o, 1'b0);
		end

		// ==========================================
		// Receive, idle-line format
		cfg(6'h00);
		rx(8'h5a, 1'b0, 1'b0, 1'b0);
		repeat (12 * N) step();
		rd();
		rx(8'ha5, 1'b0, 1'b0, 1'b0);
		repeat (3) step();
		check({rx_buffer_o, rx_irq_flag_o, rx_address_tag_o}, {8'ha5, 2'b11});
		rx(8'h3c, 1'b0, 1'b0, 1'b0);
		repeat (3) step();
		check({rx_buffer_o, rx_address_tag_o, overrun_flag_o, rx_any_error_o}, 11'h1e3);
		err_clr_i = 1'b1;
		step();
		err_clr_i = 1'b0;
		step();
		check({overrun_flag_o, rx_any_error_o}, 2'h0);
		rd();
		rx_wake_filter_enable_i = 1'b1;
		repeat (12 * N) step();
		rx(8'h81, 1'b0, 1'b0, 1'b0);
		repeat (3) step();
		check({rx_buffer_o, rx_irq_flag_o, rx_address_tag_o}, {8'h81, 2'b11});
		rd();
		rx(8'h42, 1'b0, 1'b0, 1'b0);
		repeat (3) step();
		check({rx_buffer_o, rx_irq_flag_o}, {8'h81, 1'b0});
		rx_wake_filter_enable_i = 1'b0;
		// Low stop bit, then all-zero character with low stop
		rx(8'h11, 1'b0, 1'b0, 1'b1);
		repeat (2 * N) step();
		check({framing_flag_o, line_break_flag_o, rx_any_error_o}, 3'h5);
		rd();
		rx(8'h00, 1'b0, 1'b0, 1'b1);
		repeat (2 * N) step();
		check({framing_flag_o, line_break_flag_o, rx_any_error_o}, 3'h7);
		rd();

		// ==========================================
		// Receive, address-bit format with even parity
		cfg(6'h0d);
		rx_wake_filter_enable_i = 1'b1;
		rx(8'h24, 1'b0, 1'b0, 1'b0);
		repeat (3) step();
		check(rx_irq_flag_o, 1'b0);
		rx(8'h24, 1'b1, 1'b0, 1'b0);
		repeat (3) step();
		check({rx_buffer_o, rx_irq_flag_o, rx_address_tag_o, parity_error_flag_o},
			{8'h24, 3'b110});
		rd();
		rx_wake_filter_enable_i = 1'b0;
		rx(8'h24, 1'b1, 1'b1, 1'b0);
		repeat (3) step();
		check({parity_error_flag_o, rx_any_error_o}, 2'h3);
		rd();

		// ==========================================
		// Clocked mode keeps the asynchronous transmitter quiet
		cfg(6'h20);
		put(8'h00);
		lows = 0;
		repeat (15 * N) begin
			step();
			if (serial_out_pin_o !== 1'b1) begin
				lows++;
			end
		end
		check(16'(lows), 16'h0);
		end_sim();
	end

endmodule : uart_multiprocessor_core_test

/* testbench/umc_remote_model.sv */
// Remote asynchronous serial device facing the core's two serial pins.
// Assumes the caller runs its tasks just after a rising clock edge and
// hands over whole frames, start bit at index 0.
`timescale 1ns/1ps
module umc_remote_model (
	// Clock used for bit timing
	input wire logic clock_i,
	// Serial lines
	input wire logic from_dut_i,
	output logic to_dut_o
);

	// ==========================================
	// Line idles at mark between frames
	initial begin
		to_dut_o = 1'b1;
	end

	// ==========================================
	// Send a frame, one bit every div clocks, then release to mark
	task automatic send(input logic [15:0] bits, input int n, input int div);
		for (int i = 0; i < n; i++) begin
			to_dut_o = bits[i];
			repeat (div) @(posedge clock_i);
			#1;
		end
		to_dut_o = 1'b1;
	endtask : send

	// ==========================================
	// Wait for a start bit, count idle clocks, then sample each bit mid-way
	task automatic recv(input int n, input int div, output logic [15:0] bits,
		output int idle, output logic ok);
		bits = 16'h0;
		idle = 0;
		ok = 1'b0;
		// Bounded so a silent transmitter cannot hang the run
		while (idle < 4000 && from_dut_i !== 1'b0) begin
			@(posedge clock_i);
			#1;
			idle++;
		end
		if (from_dut_i === 1'b0) begin
			ok = 1'b1;
			repeat (div / 2) @(posedge clock_i);
			#1;
			for (int i = 0; i < n; i++) begin
				bits[i] = from_dut_i;
				repeat (div) @(posedge clock_i);
				#1;
			end
		end
	endtask : recv

endmodule : umc_remote_model
